// *** shared/dtc_pkg.sv ***
package dtc_pkg;

  localparam logic [7:0] DTC_ADR_CTRL  = 8'h88;
  localparam logic [7:0] DTC_ADR_MODE  = 8'h89;
  localparam logic [7:0] DTC_ADR_CLO_A = 8'h8A;
  localparam logic [7:0] DTC_ADR_CLO_B = 8'h8B;
  localparam logic [7:0] DTC_ADR_CHI_A = 8'h8C;
  localparam logic [7:0] DTC_ADR_CHI_B = 8'h8D;
  localparam logic [7:0] DTC_ADR_STAT  = 8'h90;
  localparam logic [7:0] DTC_ADR_MASK  = 8'h91;
  localparam logic [7:0] DTC_ADR_IEN   = 8'hA8;

  localparam int CTL_OVF_B  = 7;
  localparam int CTL_RUN_B  = 6;
  localparam int CTL_OVF_A  = 5;
  localparam int CTL_RUN_A  = 4;
  localparam int CTL_EXT_B  = 3;
  localparam int CTL_TRIG_B = 2;
  localparam int CTL_EXT_A  = 1;
  localparam int CTL_TRIG_A = 0;

  localparam int MOD_GATE_B = 7;
  localparam int MOD_SRC_B  = 6;
  localparam int MOD_SEL_B  = 4;
  localparam int MOD_GATE_A = 3;
  localparam int MOD_SRC_A  = 2;
  localparam int MOD_SEL_A  = 0;

  localparam int IEN_GLOBAL = 7;
  localparam int IEN_OVF_B  = 3;
  localparam int IEN_EXT_B  = 2;
  localparam int IEN_OVF_A  = 1;
  localparam int IEN_EXT_A  = 0;

  localparam int EVT_OVF_A = 0;
  localparam int EVT_OVF_B = 1;
  localparam int EVT_EXT_A = 2;
  localparam int EVT_EXT_B = 3;
  localparam int EVT_N     = 4;

  localparam logic [7:0] DTC_RST_BYTE = 8'h00;
  localparam logic [2:0] DTC_PER_DIV  = 3'h6;
  localparam int         DTC_PRESC_W  = 5;

  typedef enum logic [1:0] {
    DTC_M_PRESC  = 2'h0,
    DTC_M_FULL   = 2'h1,
    DTC_M_RELOAD = 2'h2,
    DTC_M_SPLIT  = 2'h3
  } dtc_mode_t;

endpackage : dtc_pkg

// *** shared/dtc_cnt_if.sv ***
`timescale 1ns/1ps
interface dtc_cnt_if;
  import dtc_pkg::*;
  logic       tick_lo;
  logic       tick_hi;
  dtc_mode_t  mode;
  logic       wr_lo;
  logic       wr_hi;
  logic [7:0] wdata;
  logic [7:0] lo;
  logic [7:0] hi;
  logic       ovf_lo;
  logic       ovf_hi;
  modport ctrl (output tick_lo, tick_hi, mode, wr_lo, wr_hi, wdata,
                input  lo, hi, ovf_lo, ovf_hi);
  modport core (input  tick_lo, tick_hi, mode, wr_lo, wr_hi, wdata,
                output lo, hi, ovf_lo, ovf_hi);
endinterface : dtc_cnt_if

// *** src/dtc_cnt.sv ***
`timescale 1ns/1ps
module dtc_cnt
  import dtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  dtc_cnt_if.core  c
);

  localparam int PM = DTC_PRESC_W - 1;

  logic [7:0]  lo_q;
  logic [7:0]  lo_d;
  logic [7:0]  hi_q;
  logic [7:0]  hi_d;
  logic [15:0] full_inc;

  assign full_inc = {hi_q, lo_q} + 16'h0001;
  assign c.lo     = lo_q;
  assign c.hi     = hi_q;

  always_comb begin
    lo_d     = lo_q;
    hi_d     = hi_q;
    c.ovf_lo = 1'b0;
    c.ovf_hi = 1'b0;
    unique case (c.mode)
      DTC_M_PRESC: begin
        // Upper bits of the low byte are left alone [R08]
        if (c.tick_lo) begin
          lo_d[PM:0] = lo_q[PM:0] + 1'b1;
          if (&lo_q[PM:0]) begin
            hi_d     = hi_q + 8'h01;
            c.ovf_lo = &hi_q;
          end
        end
      end
      DTC_M_FULL: begin
        if (c.tick_lo) begin
          {hi_d, lo_d} = full_inc; // [R09]
          c.ovf_lo     = &{hi_q, lo_q};
        end
      end
      DTC_M_RELOAD: begin
        if (c.tick_lo) begin
          lo_d     = (&lo_q) ? hi_q : lo_q + 8'h01; // [R10] [R11]
          c.ovf_lo = &lo_q;
        end
      end
      DTC_M_SPLIT: begin
        if (c.tick_lo) begin
          lo_d     = lo_q + 8'h01; // [R15]
          c.ovf_lo = &lo_q;
        end
        if (c.tick_hi) begin
          hi_d     = hi_q + 8'h01; // [R15]
          c.ovf_hi = &hi_q;
        end
      end
    endcase
    // Software load wins over a count in the same cycle
    if (c.wr_lo) begin
      lo_d = c.wdata;
    end
    if (c.wr_hi) begin
      hi_d = c.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lo_q <= DTC_RST_BYTE;
      hi_q <= DTC_RST_BYTE;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

endmodule : dtc_cnt

// *** src/dtc_top.sv ***
// Overview of operation
// [R01] Each timer sets its own overflow flag in the control register when its count overflows, and that flag is its one interrupt source.
// While timer A is in mode 3 the code drops timer B's overflow and sets B's flag from timer A's high byte.
// [R02] A timer overflow flag is cleared by hardware when the processor vectors to that timer's interrupt.
// [R03] A timer interrupt request goes out only when its own enable and the global enable are both set.
// [R04] Timer B runs while its run bit is one and stops while it is zero; while timer A is in mode 3 the code runs B with the bit zero.
// [R05] With its gating bit clear timer B counts whenever running; with it set only while its gate pin is also high.
// [R06] With its source bit zero timer B counts the divided system clock.
// [R07] With its source bit one timer B counts falling edges on its count pin.
// [R08] Mode 0 makes the high byte an 8-bit counter fed by a 5-bit prescaler in the low byte.
// [R09] Mode 1 makes the two bytes one 16-bit counter.
// [R10] Mode 2 makes timer B's low byte an 8-bit counter reloaded from its high byte on overflow.
// [R11] Timer A in mode 2 reloads its low byte from its high byte on each low byte overflow.
// [R12] The external flag of channel A is set when an external interrupt is seen on gate pin A.
// [R13] In edge mode that external flag is cleared by hardware when its interrupt is taken.
// [R14] Timer B in mode 3 halts and holds its count.
// [R15] Timer A in mode 3 runs as two 8-bit timers, the high one on the clock divided by 6 using timer B's flag and run bit.
// [R16] Timer A has the same run, gating, source and mode controls as timer B in its own bits.
// [R17] Each trigger select bit picks low level when zero and falling edge when one for its external pin.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module dtc_top
  import dtc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_gate_pin_a,
  input  wire logic       ext_gate_pin_b,
  input  wire logic       ext_count_pin_a,
  input  wire logic       ext_count_pin_b,
  input  wire logic       ovf_ack_a,
  input  wire logic       ovf_ack_b,
  input  wire logic       ext_ack_a,
  input  wire logic       ext_ack_b,
  output logic            ovf_irq_req_a,
  output logic            ovf_irq_req_b,
  output logic            ext_irq_req_a,
  output logic            ext_irq_req_b,
  output logic            irq
);

  localparam int NPIN = 4;

  // Pin synchronisers: index 0 gate A, 1 gate B, 2 count A, 3 count B
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic [NPIN-1:0] pin_s3_q;
  logic [NPIN-1:0] pin_fall;

  assign pin_raw = {ext_count_pin_b, ext_count_pin_a,
                    ext_gate_pin_b, ext_gate_pin_a};

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pin_s1_q[gp] <= 1'b1;
          pin_s2_q[gp] <= 1'b1;
          pin_s3_q[gp] <= 1'b1;
        end else begin
          pin_s1_q[gp] <= pin_raw[gp];
          pin_s2_q[gp] <= pin_s1_q[gp];
          pin_s3_q[gp] <= pin_s2_q[gp];
        end
      end
      assign pin_fall[gp] = pin_s3_q[gp] & ~pin_s2_q[gp];
    end
  endgenerate

  logic gate_a;
  logic gate_b;
  logic fall_gate_a;
  logic fall_gate_b;
  logic fall_cnt_a;
  logic fall_cnt_b;

  assign gate_a      = pin_s2_q[0];
  assign gate_b      = pin_s2_q[1];
  assign fall_gate_a = pin_fall[0];
  assign fall_gate_b = pin_fall[1];
  assign fall_cnt_a  = pin_fall[2];
  assign fall_cnt_b  = pin_fall[3];

  // Peripheral clock divider for timer operation
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic       div_tick;

  assign div_tick = (div_q == DTC_PER_DIV - 3'h1);
  assign div_d    = div_tick ? 3'h0 : div_q + 3'h1;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // Register decode
  logic wr_ctrl;
  logic wr_mode;
  logic wr_stat;
  logic wr_mask;
  logic wr_ien;
  logic wr_clo_a;
  logic wr_clo_b;
  logic wr_chi_a;
  logic wr_chi_b;

  assign wr_ctrl  = reg_wr & (reg_addr == DTC_ADR_CTRL);
  assign wr_mode  = reg_wr & (reg_addr == DTC_ADR_MODE);
  assign wr_stat  = reg_wr & (reg_addr == DTC_ADR_STAT);
  assign wr_mask  = reg_wr & (reg_addr == DTC_ADR_MASK);
  assign wr_ien   = reg_wr & (reg_addr == DTC_ADR_IEN);
  assign wr_clo_a = reg_wr & (reg_addr == DTC_ADR_CLO_A);
  assign wr_clo_b = reg_wr & (reg_addr == DTC_ADR_CLO_B);
  assign wr_chi_a = reg_wr & (reg_addr == DTC_ADR_CHI_A);
  assign wr_chi_b = reg_wr & (reg_addr == DTC_ADR_CHI_B);

  // Plain read/write control bits
  logic [7:0] mode_q;
  logic [7:0] ien_q;
  logic       run_ctrl_a_q;
  logic       run_ctrl_b_q;
  logic       ext_trigger_sel_a_q;
  logic       ext_trigger_sel_b_q;
  logic [EVT_N-1:0] mask_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q              <= DTC_RST_BYTE;
      ien_q               <= DTC_RST_BYTE;
      run_ctrl_a_q        <= 1'b0;
      run_ctrl_b_q        <= 1'b0;
      ext_trigger_sel_a_q <= 1'b0;
      ext_trigger_sel_b_q <= 1'b0;
      mask_q              <= '0;
    end else begin
      if (wr_mode) begin
        mode_q <= reg_wdata;
      end
      if (wr_ien) begin
        ien_q <= reg_wdata;
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[EVT_N-1:0];
      end
      if (wr_ctrl) begin
        run_ctrl_a_q        <= reg_wdata[CTL_RUN_A]; // [R16]
        run_ctrl_b_q        <= reg_wdata[CTL_RUN_B]; // [R04]
        ext_trigger_sel_a_q <= reg_wdata[CTL_TRIG_A];
        ext_trigger_sel_b_q <= reg_wdata[CTL_TRIG_B];
      end
    end
  end

  // Mode fields
  logic      gating_sel_a;
  logic      gating_sel_b;
  logic      count_src_a;
  logic      count_src_b;
  dtc_mode_t mode_a;
  dtc_mode_t mode_b;
  logic      a_split;
  logic      b_halt;

  assign gating_sel_a = mode_q[MOD_GATE_A];
  assign gating_sel_b = mode_q[MOD_GATE_B];
  assign count_src_a  = mode_q[MOD_SRC_A];
  assign count_src_b  = mode_q[MOD_SRC_B];
  assign mode_a       = dtc_mode_t'(mode_q[MOD_SEL_A +: 2]);
  assign mode_b       = dtc_mode_t'(mode_q[MOD_SEL_B +: 2]);
  assign a_split      = (mode_a == DTC_M_SPLIT);
  assign b_halt       = (mode_b == DTC_M_SPLIT);

  // Count enables
  logic run_a;
  logic run_b;
  logic src_a;
  logic src_b;
  logic run_b_bit;

  assign run_a = run_ctrl_a_q & (~gating_sel_a | gate_a); // [R16]
  // While A is split, B has lost its run bit and runs unless halted or gated off
  assign run_b_bit = a_split | run_ctrl_b_q; // [R15]
  assign run_b = run_b_bit & (~gating_sel_b | gate_b); // [R04] [R05]
  assign src_a = count_src_a ? fall_cnt_a : div_tick; // [R16]
  assign src_b = count_src_b ? fall_cnt_b : div_tick; // [R06] [R07]

  dtc_cnt_if cif [2] ();

  assign cif[0].tick_lo = run_a & src_a;
  assign cif[0].tick_hi = a_split & run_ctrl_b_q & div_tick; // [R15]
  assign cif[0].mode    = mode_a;
  assign cif[0].wr_lo   = wr_clo_a;
  assign cif[0].wr_hi   = wr_chi_a;
  assign cif[0].wdata   = reg_wdata;

  assign cif[1].tick_lo = run_b & src_b & ~b_halt; // [R14]
  assign cif[1].tick_hi = 1'b0;
  assign cif[1].mode    = mode_b;
  assign cif[1].wr_lo   = wr_clo_b;
  assign cif[1].wr_hi   = wr_chi_b;
  assign cif[1].wdata   = reg_wdata;

  genvar gt;
  generate
    for (gt = 0; gt < 2; gt++) begin : g_tmr
      dtc_cnt u_cnt (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .c       (cif[gt])
      );
    end
  endgenerate

  // Flag set events
  logic ovf_set_a;
  logic ovf_set_b;
  logic ext_set_a;
  logic ext_set_b;

  assign ovf_set_a = cif[0].ovf_lo; // [R01]
  // Split timer A high byte owns B's flag; B's own overflow is lost then
  assign ovf_set_b = a_split ? cif[0].ovf_hi : cif[1].ovf_lo; // [R01] [R15]
  assign ext_set_a = ext_trigger_sel_a_q ? fall_gate_a : ~gate_a; // [R12] [R17]
  assign ext_set_b = ext_trigger_sel_b_q ? fall_gate_b : ~gate_b; // [R17]

  // Hardware-set flags; a set beats a write or an acknowledge
  logic overflow_flag_a_q;
  logic overflow_flag_b_q;
  logic ext_edge_flag_a_q;
  logic ext_edge_flag_b_q;
  logic ovf_a_keep;
  logic ovf_b_keep;
  logic ext_a_keep;
  logic ext_b_keep;

  assign ovf_a_keep = wr_ctrl ? reg_wdata[CTL_OVF_A]
                              : overflow_flag_a_q & ~ovf_ack_a; // [R02]
  assign ovf_b_keep = wr_ctrl ? reg_wdata[CTL_OVF_B]
                              : overflow_flag_b_q & ~ovf_ack_b; // [R02]
  assign ext_a_keep = wr_ctrl ? reg_wdata[CTL_EXT_A]
                              : ext_edge_flag_a_q & ~ext_ack_a; // [R13]
  assign ext_b_keep = wr_ctrl ? reg_wdata[CTL_EXT_B]
                              : ext_edge_flag_b_q & ~ext_ack_b; // [R13]

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      overflow_flag_a_q <= 1'b0;
      overflow_flag_b_q <= 1'b0;
      ext_edge_flag_a_q <= 1'b0;
      ext_edge_flag_b_q <= 1'b0;
    end else begin
      overflow_flag_a_q <= ovf_set_a | ovf_a_keep; // [R01]
      overflow_flag_b_q <= ovf_set_b | ovf_b_keep; // [R01]
      // Level mode follows the pin, so software cannot latch it
      ext_edge_flag_a_q <= ext_trigger_sel_a_q ? (ext_set_a | ext_a_keep)
                                               : ext_set_a; // [R12] [R17]
      ext_edge_flag_b_q <= ext_trigger_sel_b_q ? (ext_set_b | ext_b_keep)
                                               : ext_set_b; // [R17]
    end
  end

  // Sticky event status, write one to clear
  logic [EVT_N-1:0] evt;
  logic [EVT_N-1:0] stat_q;
  logic [EVT_N-1:0] stat_clr;

  assign evt[EVT_OVF_A] = ovf_set_a;
  assign evt[EVT_OVF_B] = ovf_set_b;
  assign evt[EVT_EXT_A] = ext_set_a & ext_trigger_sel_a_q;
  assign evt[EVT_EXT_B] = ext_set_b & ext_trigger_sel_b_q;
  assign stat_clr = wr_stat ? reg_wdata[EVT_N-1:0] : '0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
    end else begin
      stat_q <= evt | (stat_q & ~stat_clr);
    end
  end

  // Interrupt requests toward the interrupt controller
  logic req_ovf_a;
  logic req_ovf_b;
  logic req_ext_a;
  logic req_ext_b;
  logic glob_en;

  assign glob_en   = ien_q[IEN_GLOBAL];
  assign req_ovf_a = glob_en & ien_q[IEN_OVF_A] & overflow_flag_a_q; // [R03]
  assign req_ovf_b = glob_en & ien_q[IEN_OVF_B] & overflow_flag_b_q; // [R03]
  assign req_ext_a = glob_en & ien_q[IEN_EXT_A] & ext_edge_flag_a_q;
  assign req_ext_b = glob_en & ien_q[IEN_EXT_B] & ext_edge_flag_b_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ovf_irq_req_a <= 1'b0;
      ovf_irq_req_b <= 1'b0;
      ext_irq_req_a <= 1'b0;
      ext_irq_req_b <= 1'b0;
      irq           <= 1'b0;
    end else begin
      ovf_irq_req_a <= req_ovf_a;
      ovf_irq_req_b <= req_ovf_b;
      ext_irq_req_a <= req_ext_a;
      ext_irq_req_b <= req_ext_b;
      irq           <= |(stat_q & mask_q);
    end
  end

  // Read path, one cycle latency, unmapped reads as zero
  logic [7:0] ctrl_rd;
  logic [7:0] rd_mux;

  assign ctrl_rd = {overflow_flag_b_q, run_ctrl_b_q,
                    overflow_flag_a_q, run_ctrl_a_q,
                    ext_edge_flag_b_q, ext_trigger_sel_b_q,
                    ext_edge_flag_a_q, ext_trigger_sel_a_q};

  always_comb begin
    unique case (reg_addr)
      DTC_ADR_CTRL:  rd_mux = ctrl_rd;
      DTC_ADR_MODE:  rd_mux = mode_q;
      DTC_ADR_CLO_A: rd_mux = cif[0].lo;
      DTC_ADR_CLO_B: rd_mux = cif[1].lo;
      DTC_ADR_CHI_A: rd_mux = cif[0].hi;
      DTC_ADR_CHI_B: rd_mux = cif[1].hi;
      DTC_ADR_STAT:  rd_mux = {{(8-EVT_N){1'b0}}, stat_q};
      DTC_ADR_MASK:  rd_mux = {{(8-EVT_N){1'b0}}, mask_q};
      DTC_ADR_IEN:   rd_mux = ien_q;
      default:       rd_mux = DTC_RST_BYTE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= DTC_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= DTC_RST_BYTE;
    end
  end

endmodule : dtc_top

// *** verification/dtc_top_sva.sv ***
`timescale 1ns/1ps
module dtc_top_sva
  import dtc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ovf_irq_req_a,
  input wire logic       ovf_irq_req_b,
  input wire logic       ext_irq_req_a,
  input wire logic       ext_irq_req_b,
  input wire logic       irq
);
  // Shadows of written bytes; only bits that hardware never moves are used
  logic [7:0] ctl_q;
  logic [7:0] mod_q;
  logic [7:0] ien_q;
  logic [7:0] msk_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= 8'h00;
      mod_q <= 8'h00;
      ien_q <= 8'h00;
      msk_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == DTC_ADR_CTRL) ctl_q <= reg_wdata;
      if (reg_addr == DTC_ADR_MODE) mod_q <= reg_wdata;
      if (reg_addr == DTC_ADR_IEN) ien_q <= reg_wdata;
      if (reg_addr == DTC_ADR_MASK) msk_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_rd_ctl;
    reg_rd && reg_addr == DTC_ADR_CTRL;
  endsequence
  sequence s_rd_mod;
    reg_rd && reg_addr == DTC_ADR_MODE;
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside its slot");
  a_ovf_req_a: assert property (ovf_irq_req_a |->
    $past(ien_q[IEN_GLOBAL]) && $past(ien_q[IEN_OVF_A]))
    else $error("timer A request without enables");
  a_ovf_req_b: assert property (ovf_irq_req_b |->
    $past(ien_q[IEN_GLOBAL]) && $past(ien_q[IEN_OVF_B]))
    else $error("timer B request without enables");
  a_ext_req_a: assert property (ext_irq_req_a |->
    $past(ien_q[IEN_GLOBAL]) && $past(ien_q[IEN_EXT_A]))
    else $error("external A request without enables");
  a_ext_req_b: assert property (ext_irq_req_b |->
    $past(ien_q[IEN_GLOBAL]) && $past(ien_q[IEN_EXT_B]))
    else $error("external B request without enables");
  a_irq_needs_mask: assert property (irq |-> $past(msk_q) != 8'h00)
    else $error("interrupt line high with all events masked");
  a_run_bits_read: assert property (s_rd_ctl |=>
    reg_rdata[CTL_RUN_B] == ctl_q[CTL_RUN_B] &&
    reg_rdata[CTL_RUN_A] == ctl_q[CTL_RUN_A])
    else $error("run bits read back wrong");
  a_trig_bits_read: assert property (s_rd_ctl |=>
    reg_rdata[CTL_TRIG_B] == ctl_q[CTL_TRIG_B] &&
    reg_rdata[CTL_TRIG_A] == ctl_q[CTL_TRIG_A])
    else $error("trigger select bits read back wrong");
  a_mode_byte_read: assert property (s_rd_mod |=> reg_rdata == mod_q)
    else $error("mode byte read back wrong");
endmodule : dtc_top_sva
bind dtc_top dtc_top_sva chk_u (.ref_clk, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .ovf_irq_req_a, .ovf_irq_req_b,
  .ext_irq_req_a, .ext_irq_req_b, .irq);

// *** verification/dtc_pin_model.sv ***
`timescale 1ns/1ps
module dtc_pin_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic go,
  output logic      pin
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  // Three cycles low then at least four high, so the two-stage sync never misses it
  assign cnt_d = (cnt_q != 3'h0) ? cnt_q - 3'h1 : (go ? 3'h6 : 3'h0);
  assign pin   = (cnt_q <= 3'h3);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) cnt_q <= 3'h0;
    else cnt_q <= cnt_d;
  end
endmodule : dtc_pin_model

// *** verification/dtc_top_test.sv ***
`timescale 1ns/1ps
module dtc_top_test;
  logic       ref_clk;
  logic       rstn;
  logic       reg_wr;
  logic       reg_rd;
  logic       ga;
  logic       gb;
  logic       pa;
  logic       pb;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [4:0] rq;
  logic [3:0] ack;
  logic [1:0] go;
  int         err_total;
  int         tests_run;
  logic [7:0] al [9] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h90,
                         8'h91, 8'hA8};
  dtc_top dut_u (
    .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_gate_pin_a(ga), .ext_gate_pin_b(gb),
    .ext_count_pin_a(pa), .ext_count_pin_b(pb),
    .ovf_ack_a(ack[0]), .ovf_ack_b(ack[1]),
    .ext_ack_a(ack[2]), .ext_ack_b(ack[3]),
    .ovf_irq_req_a(rq[0]), .ovf_irq_req_b(rq[1]),
    .ext_irq_req_a(rq[2]), .ext_irq_req_b(rq[3]), .irq(rq[4])
  );
  dtc_pin_model pin_a_u (.ref_clk, .rstn, .go(go[0]), .pin(pa));
  dtc_pin_model pin_b_u (.ref_clk, .rstn, .go(go[1]), .pin(pb));
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task report_and_stop();
    $display("tests=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task ck(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : ck
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : rd
  task rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    ck(d, e);
  endtask : rc
  task wq(input int w, input logic v);
    int i;
    i = 0;
    #1;
    while (rq[w] !== v && i < 40) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    ck({7'h00, rq[w]}, {7'h00, v});
  endtask : wq
  task fall(input int b);
    @(posedge ref_clk) go[b] <= 1'h1;
    @(posedge ref_clk) go <= 2'h0;
    repeat (8) @(posedge ref_clk);
  endtask : fall
  task pul(input int w);
    @(posedge ref_clk) ack[w] <= 1'h1;
    @(posedge ref_clk) ack <= 4'h0;
  endtask : pul
  task t_reset();
    foreach (al[i]) rc(al[i], 8'h00);
    wr(8'h00, 8'hFF);
    rc(8'h00, 8'h00);
    $display("done t_reset");
  endtask : t_reset
  task t_full_b();
    wr(8'h89, 8'h50);
    wr(8'hA8, 8'h88);
    wr(8'h8B, 8'hFE);
    wr(8'h8D, 8'hFF);
    wr(8'h88, 8'h40);
    fall(1);
    rc(8'h8B, 8'hFF);
    rc(8'h8D, 8'hFF);
    fall(1);
    wq(1, 1'h1);
    rc(8'h8B, 8'h00);
    rc(8'h8D, 8'h00);
    rc(8'h88, 8'hC0);
    rc(8'h90, 8'h02);
    wr(8'h91, 8'h02);
    wq(4, 1'h1);
    pul(1);
    wq(1, 1'h0);
    rc(8'h88, 8'h40);
    wr(8'h90, 8'h02);
    wq(4, 1'h0);
    wr(8'h91, 8'h00);
    wr(8'h88, 8'h00);
    $display("done t_full_b");
  endtask : t_full_b
  task t_presc_a();
    wr(8'h89, 8'h04);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'h05);
    wr(8'h88, 8'h10);
    fall(0);
    fall(0);
    rc(8'h8A, 8'hE0);
    rc(8'h8C, 8'h06);
    wr(8'h88, 8'h00);
    $display("done t_presc_a");
  endtask : t_presc_a
  task t_reload_a();
    wr(8'hA8, 8'h02);
    wr(8'h89, 8'h06);
    wr(8'h8C, 8'h80);
    wr(8'h8A, 8'hFF);
    wr(8'h88, 8'h10);
    fall(0);
    rc(8'h8A, 8'h80);
    rc(8'h8C, 8'h80);
    rc(8'h88, 8'h30);
    ck({7'h00, rq[0]}, 8'h00);
    wr(8'hA8, 8'h82);
    wq(0, 1'h1);
    pul(0);
    wq(0, 1'h0);
    rc(8'h88, 8'h10);
    wr(8'h88, 8'h00);
    rc(8'h88, 8'h00);
    $display("done t_reload_a");
  endtask : t_reload_a
  task t_reload_b();
    wr(8'h89, 8'h60);
    wr(8'h8D, 8'h40);
    wr(8'h8B, 8'hFF);
    wr(8'h88, 8'h40);
    fall(1);
    rc(8'h8B, 8'h40);
    wr(8'h89, 8'h70);
    fall(1);
    fall(1);
    rc(8'h8B, 8'h40);
    wr(8'h88, 8'h00);
    $display("done t_reload_b");
  endtask : t_reload_b
  task t_gate_b();
    wr(8'h89, 8'hD0);
    wr(8'h8B, 8'h00);
    @(posedge ref_clk) gb <= 1'h0;
    wr(8'h88, 8'h40);
    fall(1);
    rc(8'h8B, 8'h00);
    @(posedge ref_clk) gb <= 1'h1;
    fall(1);
    rc(8'h8B, 8'h01);
    wr(8'h88, 8'h00);
    fall(1);
    rc(8'h8B, 8'h01);
    $display("done t_gate_b");
  endtask : t_gate_b
  task t_timer_b();
    logic [7:0] d;
    wr(8'h89, 8'h10);
    wr(8'h8B, 8'h00);
    wr(8'h88, 8'h40);
    repeat (60) @(posedge ref_clk);
    wr(8'h88, 8'h00);
    rd(8'h8B, d);
    // The free-running divider phase leaves one tick of slack either way
    ck({7'h00, d >= 8'h09 && d <= 8'h0B}, 8'h01);
    $display("done t_timer_b");
  endtask : t_timer_b
  task t_ext_a();
    wr(8'hA8, 8'h81);
    wr(8'h88, 8'h01);
    @(posedge ref_clk) ga <= 1'h0;
    wq(2, 1'h1);
    rc(8'h88, 8'h03);
    pul(2);
    wq(2, 1'h0);
    rc(8'h88, 8'h01);
    @(posedge ref_clk) ga <= 1'h1;
    wr(8'h88, 8'h00);
    @(posedge ref_clk) ga <= 1'h0;
    wq(2, 1'h1);
    pul(2);
    rc(8'h88, 8'h02);
    @(posedge ref_clk) ga <= 1'h1;
    wq(2, 1'h0);
    wr(8'hA8, 8'h84);
    wr(8'h88, 8'h04);
    @(posedge ref_clk) gb <= 1'h0;
    wq(3, 1'h1);
    rc(8'h88, 8'h0C);
    pul(3);
    wq(3, 1'h0);
    @(posedge ref_clk) gb <= 1'h1;
    $display("done t_ext_a");
  endtask : t_ext_a
  task t_split_a();
    wr(8'hA8, 8'h88);
    wr(8'h89, 8'h03);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h40);
    wq(1, 1'h1);
    rc(8'h8C, 8'h00);
    rc(8'h88, 8'hC0);
    $display("done t_split_a");
  endtask : t_split_a
  initial begin
    repeat (6000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    rstn      = 1'h0;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    ga        = 1'h1;
    gb        = 1'h1;
    ack       = 4'h0;
    go        = 2'h0;
    err_total = 0;
    tests_run = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'h1;
    t_reset();
    t_full_b();
    t_presc_a();
    t_reload_a();
    t_reload_b();
    t_gate_b();
    t_timer_b();
    t_ext_a();
    t_split_a();
    report_and_stop();
  end
endmodule : dtc_top_test
